/* File: logic/brg_div_counter.sv */
// Programmable 8-bit divider counter with match detector and divide-by-two stage
`timescale 1ns/10ps
`default_nettype none

module brg_div_counter #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic base_tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [CW-1:0] divisor,
  // State
  output logic [CW-1:0] count,
  output logic match,
  output logic phase
);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic phase_r;
  logic phase_nxt;
  logic [CW-1:0] count_inc;

  // Match when the next count would reach the divisor
  always_comb
  begin
    count_inc = count_r + {{(CW-1){1'b0}}, 1'b1};
    match = run && !clear && base_tick && (count_inc == divisor);
    count_nxt = count_r;
    phase_nxt = phase_r;
    if (!run || clear)
    begin
      count_nxt = '0;
      phase_nxt = 1'b0;
    end
    else if (match)
    begin
      count_nxt = '0;
      phase_nxt = !phase_r;
    end
    else if (base_tick)
    begin
      count_nxt = count_inc;
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= '0;
      phase_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign count = count_r;
  assign phase = phase_r;

endmodule

`default_nettype wire

/* File: logic/brg_top.sv */
// Bit rate generator of one serial channel with APB registers and receive start detection
`timescale 1ns/10ps
`default_nettype none

module brg_top #(
  parameter int FRAME_BITS = brg_pkg::BRG_RX_FRAME_BITS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit side
  input wire logic tx_frame_end,
  output logic tx_serial_clk,
  output logic [7:0] tx_buffer_data,
  output logic tx_buffer_load,
  // Receive side
  input wire logic serial_receive_pin,
  output logic rx_serial_clk,
  output logic rx_bit_strobe,
  output logic rx_bit_value,
  output logic rx_frame_done
);

  // Register state
  brg_pkg::brg_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] divisor_r, divisor_nxt, txb_r, txb_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic tx_busy_r, tx_busy_nxt, tx_pend_r, tx_pend_nxt;
  logic tx_load_r, tx_load_nxt, half_div_r, half_div_nxt;

  // Receive state
  brg_pkg::brg_rx_state_t rx_state_r, rx_state_nxt;
  logic rx_meta_r, rx_sync_r, rx_samp_r, rx_prev_r;
  logic rx_filt_r, rx_filt_nxt, rx_half_r, rx_half_nxt;
  logic [3:0] rx_bits_r, rx_bits_nxt;
  logic rx_strobe_r, rx_strobe_nxt, rx_value_r, rx_value_nxt;
  logic rx_done_r, rx_done_nxt;

  // Combinational helpers
  logic access, wr_en, txb_write, base_tick, tx_run, tx_clear;
  logic rx_run, rx_start_lvl, rx_start_edge, rx_match;
  logic [7:0] tx_count, rx_count;

  localparam logic [3:0] RX_LAST_BIT = 4'(FRAME_BITS - 1);

  // Address decode shared by read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == brg_pkg::BRG_OFS_CTRL) || (a == brg_pkg::BRG_OFS_DIV) ||
                 (a == brg_pkg::BRG_OFS_TXB) || (a == brg_pkg::BRG_OFS_STATUS);
  endfunction

  // Base clock as an enable: every pclk when doubled, every other otherwise
  always_comb
  begin
    half_div_nxt = ctrl_r.channel_power_bit ? !half_div_r : 1'b0;
    base_tick = ctrl_r.channel_power_bit && (ctrl_r.base_clock_double_select || half_div_r);
  end

  // APB access and register next values
  always_comb
  begin
    access = psel && penable && !pready_r;
    wr_en = access && pwrite && addr_known(paddr);
    txb_write = wr_en && (paddr == brg_pkg::BRG_OFS_TXB);
    ctrl_nxt = ctrl_r;
    divisor_nxt = divisor_r;
    txb_nxt = txb_r;
    pready_nxt = access;
    pslverr_nxt = access && !addr_known(paddr);
    prdata_nxt = prdata_r;
    // Control fields sit contiguously from the power bit down, in struct order
    if (wr_en && paddr == brg_pkg::BRG_OFS_CTRL)
      ctrl_nxt = brg_pkg::brg_ctrl_t'(pwdata[brg_pkg::BRG_CTRL_POWER_BIT -: $bits(brg_pkg::brg_ctrl_t)]);
    // Divisors below the minimum are dropped so the counter never sees 0 or 1
    if (wr_en && paddr == brg_pkg::BRG_OFS_DIV && pwdata[7:0] >= brg_pkg::BRG_DIV_MIN)
      divisor_nxt = pwdata[7:0];
    if (txb_write)
      txb_nxt = pwdata[7:0];
    // Refused writes clear read data too, so an error answer always carries zero
    if (access && (!pwrite || !addr_known(paddr)))
    begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        brg_pkg::BRG_OFS_CTRL: prdata_nxt[brg_pkg::BRG_CTRL_POWER_BIT -: $bits(brg_pkg::brg_ctrl_t)] = ctrl_r;
        brg_pkg::BRG_OFS_DIV: prdata_nxt[7:0] = divisor_r;
        brg_pkg::BRG_OFS_TXB: prdata_nxt[7:0] = txb_r;
        brg_pkg::BRG_OFS_STATUS:
        begin
          prdata_nxt[brg_pkg::BRG_STAT_TXCNT_LSB +: 8] = tx_count;
          prdata_nxt[brg_pkg::BRG_STAT_RXCNT_LSB +: 8] = rx_count;
          prdata_nxt[brg_pkg::BRG_STAT_RXACT_BIT] = (rx_state_r != brg_pkg::BRG_RX_IDLE);
          prdata_nxt[brg_pkg::BRG_STAT_TXBUSY_BIT] = tx_busy_r;
          prdata_nxt[brg_pkg::BRG_STAT_TXPEND_BIT] = tx_pend_r;
          prdata_nxt[brg_pkg::BRG_STAT_RXLVL_BIT] = rx_filt_r;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Transmit buffer tracking: first write or frame end with data waiting restarts the count
  always_comb
  begin
    tx_run = ctrl_r.channel_power_bit && ctrl_r.transmit_enable_bit;
    tx_clear = (txb_write && !tx_busy_r) ||
               (tx_frame_end && (tx_pend_r || txb_write));
    tx_load_nxt = txb_write;
    tx_busy_nxt = tx_busy_r;
    tx_pend_nxt = tx_pend_r;
    if (!tx_run)
    begin
      tx_busy_nxt = 1'b0;
      tx_pend_nxt = 1'b0;
    end
    else
    begin
      // Write at frame end with data already waiting stays pending: set beats clear
      tx_pend_nxt = (tx_pend_r && !tx_frame_end) || (txb_write && tx_busy_r && (tx_pend_r || !tx_frame_end));
      tx_busy_nxt = txb_write || (tx_busy_r && !(tx_frame_end && !tx_pend_r));
    end
  end

  // Transmit and receive counters are fully separate instances
  brg_div_counter #(.CW(8)) u_tx_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .base_tick(base_tick),
    .run(tx_run),
    .clear(tx_clear),
    .divisor(divisor_r),
    .count(tx_count),
    .match(),
    .phase(tx_serial_clk)
  );

  brg_div_counter #(.CW(8)) u_rx_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .base_tick(base_tick),
    .run(rx_run),
    .clear(1'b0),
    .divisor(divisor_r),
    .count(rx_count),
    .match(rx_match),
    .phase(rx_serial_clk)
  );

  // Noise filter and receive sequencer
  always_comb
  begin
    rx_filt_nxt = (rx_sync_r == rx_samp_r) ? rx_sync_r : rx_filt_r;
    rx_start_lvl = ctrl_r.line_level_invert;
    rx_start_edge = (rx_prev_r != rx_filt_r) && (rx_filt_r == rx_start_lvl);
    rx_run = ctrl_r.channel_power_bit && ctrl_r.receive_enable_bit &&
             (rx_state_r != brg_pkg::BRG_RX_IDLE);
    rx_state_nxt = rx_state_r;
    rx_half_nxt = rx_half_r;
    rx_bits_nxt = rx_bits_r;
    rx_strobe_nxt = 1'b0;
    rx_value_nxt = rx_value_r;
    rx_done_nxt = 1'b0;
    if (!(ctrl_r.channel_power_bit && ctrl_r.receive_enable_bit))
      rx_state_nxt = brg_pkg::BRG_RX_IDLE;
    else
    begin
      unique case (rx_state_r)
        brg_pkg::BRG_RX_IDLE:
          if (rx_start_edge)
            rx_state_nxt = brg_pkg::BRG_RX_START;
        brg_pkg::BRG_RX_START:
        begin
          // Resample half a bit in; a glitch returns to idle
          if (rx_match)
          begin
            rx_state_nxt = (rx_filt_r == rx_start_lvl) ? brg_pkg::BRG_RX_DATA : brg_pkg::BRG_RX_IDLE;
            rx_half_nxt = 1'b0;
            rx_bits_nxt = 4'h0;
          end
        end
        brg_pkg::BRG_RX_DATA:
        begin
          if (rx_match)
          begin
            rx_half_nxt = !rx_half_r;
            if (rx_half_r)
            begin
              // Latch at mid-bit, one base clock of margin to the match point
              rx_strobe_nxt = 1'b1;
              rx_value_nxt = rx_filt_r ^ ctrl_r.line_level_invert;
              rx_bits_nxt = rx_bits_r + 4'h1;
              if (rx_bits_r + 4'h1 == RX_LAST_BIT)
              begin
                rx_done_nxt = 1'b1;
                rx_state_nxt = brg_pkg::BRG_RX_IDLE;
              end
            end
          end
        end
        default: rx_state_nxt = brg_pkg::BRG_RX_IDLE;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= brg_pkg::brg_ctrl_t'(5'(brg_pkg::BRG_CTRL_RESET));
      divisor_r <= brg_pkg::BRG_DIV_RESET;
      txb_r <= brg_pkg::BRG_TXB_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      tx_busy_r <= 1'b0;
      tx_pend_r <= 1'b0;
      tx_load_r <= 1'b0;
      half_div_r <= 1'b0;
      rx_state_r <= brg_pkg::BRG_RX_IDLE;
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_samp_r <= 1'b1;
      rx_filt_r <= 1'b1;
      rx_prev_r <= 1'b1;
      rx_half_r <= 1'b0;
      rx_bits_r <= 4'h0;
      rx_strobe_r <= 1'b0;
      rx_value_r <= 1'b0;
      rx_done_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      divisor_r <= divisor_nxt;
      txb_r <= txb_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      tx_busy_r <= tx_busy_nxt;
      tx_pend_r <= tx_pend_nxt;
      tx_load_r <= tx_load_nxt;
      half_div_r <= half_div_nxt;
      rx_state_r <= rx_state_nxt;
      rx_meta_r <= serial_receive_pin;
      rx_sync_r <= rx_meta_r;
      rx_samp_r <= rx_sync_r;
      rx_filt_r <= rx_filt_nxt;
      rx_prev_r <= rx_filt_r;
      rx_half_r <= rx_half_nxt;
      rx_bits_r <= rx_bits_nxt;
      rx_strobe_r <= rx_strobe_nxt;
      rx_value_r <= rx_value_nxt;
      rx_done_r <= rx_done_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_buffer_data = txb_r;
  assign tx_buffer_load = tx_load_r;
  assign rx_bit_strobe = rx_strobe_r;
  assign rx_bit_value = rx_value_r;
  assign rx_frame_done = rx_done_r;

endmodule

`default_nettype wire

/* File: shared/brg_pkg.sv */
// Package for the serial channel bit rate generator: register map, fields, types
package brg_pkg;

  // Register byte offsets
  localparam logic [7:0] BRG_OFS_CTRL = 8'h00;
  localparam logic [7:0] BRG_OFS_DIV = 8'h04;
  localparam logic [7:0] BRG_OFS_TXB = 8'h08;
  localparam logic [7:0] BRG_OFS_STATUS = 8'h0C;

  // Control register field positions
  localparam int BRG_CTRL_POWER_BIT = 7;
  localparam int BRG_CTRL_TXE_BIT = 6;
  localparam int BRG_CTRL_RXE_BIT = 5;
  localparam int BRG_CTRL_ALV_BIT = 4;
  localparam int BRG_CTRL_DBL_BIT = 3;

  // Status register field positions
  localparam int BRG_STAT_TXCNT_LSB = 0;
  localparam int BRG_STAT_RXCNT_LSB = 8;
  localparam int BRG_STAT_RXACT_BIT = 16;
  localparam int BRG_STAT_TXBUSY_BIT = 17;
  localparam int BRG_STAT_TXPEND_BIT = 18;
  localparam int BRG_STAT_RXLVL_BIT = 19;

  // Reset values and divisor limit
  localparam logic [7:0] BRG_CTRL_RESET = 8'h00;
  localparam logic [7:0] BRG_DIV_RESET = 8'hFF;
  localparam logic [7:0] BRG_TXB_RESET = 8'h00;
  localparam logic [7:0] BRG_DIV_MIN = 8'h02;

  // Receive frame: start bit plus ten further bits
  localparam int BRG_RX_FRAME_BITS = 11;

  // Operation mode control bits
  typedef struct packed {
    logic channel_power_bit;
    logic transmit_enable_bit;
    logic receive_enable_bit;
    logic line_level_invert;
    logic base_clock_double_select;
  } brg_ctrl_t;

  // Receive sampler states
  typedef enum logic [2:0] {
    BRG_RX_IDLE = 3'b001,
    BRG_RX_START = 3'b010,
    BRG_RX_DATA = 3'b100
  } brg_rx_state_t;

endpackage

/* File: tb/brg_remote_uart.sv */
// Remote serial transmitter model driving the receive pin
`timescale 1ns/10ps
`default_nettype none

module brg_remote_uart (
  // Clock
  input wire logic pclk,
  // Polarity and line
  input wire logic inv,
  output logic line
);
  logic d_r = 1'b1;

  // Idle level follows polarity, so the pin rests before power-up
  assign line = d_r ^ inv;

  // Start, eight data bits low first, even parity, stop at nominal rate
  task send(input logic [7:0] b, input int bitcyc);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      d_r <= f[i];
      repeat (bitcyc) @(posedge pclk);
    end
    d_r <= 1'b1;
  endtask

  // Short start-level pulse that must not open a frame
  task pulse(input int cyc);
    d_r <= 1'b0;
    repeat (cyc) @(posedge pclk);
    d_r <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: tb/brg_top_chk.sv */
// Checker: port-level properties of the bit rate generator
`timescale 1ns/10ps
`default_nettype none

module brg_top_chk #(
  parameter int FRAME_BITS = brg_pkg::BRG_RX_FRAME_BITS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Transmit side
  input wire logic tx_frame_end,
  input wire logic tx_serial_clk,
  input wire logic [7:0] tx_buffer_data,
  input wire logic tx_buffer_load,
  // Receive side
  input wire logic serial_receive_pin,
  input wire logic rx_serial_clk,
  input wire logic rx_bit_strobe,
  input wire logic rx_bit_value,
  input wire logic rx_frame_done
);
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic tx_on;
  logic rx_on;

  // Shadow control word; lags the real one by a cycle, so off-checks wait two
  always_comb
  begin
    ctrl_nxt = (psel && penable && pready && pwrite && paddr == 8'h00) ? pwdata[7:0] : ctrl_r;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= 8'h00;
    else
      ctrl_r <= ctrl_nxt;
  end
  assign tx_on = ctrl_r[7] && ctrl_r[6];
  assign rx_on = ctrl_r[7] && ctrl_r[5];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answer timing and refusal
  AST_PREADY_ANSWER: assert property ($rose(psel && penable) |=> pready) else $error("no answer");
  AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready too long");
  AST_ERR_UNMAPPED: assert property ((psel && penable && !pready && paddr > 8'h0C)
    |=> pready && pslverr && prdata == 32'h0) else $error("unmapped not refused");
  AST_DIV_FLOOR: assert property ((psel && pready && !pwrite && paddr == 8'h04) |-> prdata[7:0] >= 8'h02)
    else $error("divisor below two");
  // Clocks and receive strobes stopped by the control bits
  AST_BASE_OFF: assert property (!ctrl_r[7] [*2] |-> !tx_serial_clk && !rx_serial_clk && !rx_bit_strobe)
    else $error("clock while powered off");
  AST_TX_HELD: assert property (!tx_on [*2] |-> !tx_serial_clk) else $error("tx clock while disabled");
  AST_RX_HELD: assert property (!rx_on [*2] |-> !rx_serial_clk && !rx_bit_strobe && !rx_frame_done)
    else $error("rx active while disabled");
  // Buffer load and receive strobes
  AST_TX_LOAD: assert property ((psel && penable && !pready && pwrite && paddr == 8'h08)
    |=> tx_buffer_load && tx_buffer_data == $past(pwdata[7:0])) else $error("buffer load wrong");
  AST_LOAD_PULSE: assert property (tx_buffer_load |=> !tx_buffer_load) else $error("load too long");
  AST_DONE_LAST: assert property (rx_frame_done |-> rx_bit_strobe) else $error("done without strobe");
  AST_STROBE_GAP: assert property (rx_bit_strobe |=> !rx_bit_strobe [*3]) else $error("strobes too close");
  AST_DONE_GAP: assert property (rx_frame_done |=> !rx_frame_done [*8]) else $error("done repeated");
endmodule

bind brg_top brg_top_chk #(.FRAME_BITS(FRAME_BITS)) brg_top_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_frame_end(tx_frame_end), .tx_serial_clk(tx_serial_clk),
  .tx_buffer_data(tx_buffer_data), .tx_buffer_load(tx_buffer_load), .serial_receive_pin(serial_receive_pin),
  .rx_serial_clk(rx_serial_clk), .rx_bit_strobe(rx_bit_strobe), .rx_bit_value(rx_bit_value),
  .rx_frame_done(rx_frame_done));
`default_nettype wire

/* File: tb/brg_top_tb_top.sv */
// Testbench top: APB register tests, transmit clocking and receive frames
`timescale 1ns/10ps
`default_nettype none

module brg_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tx_frame_end = 1'b0;
  logic tx_serial_clk;
  logic [7:0] tx_buffer_data;
  logic tx_buffer_load;
  logic serial_receive_pin;
  logic rx_serial_clk;
  logic rx_bit_strobe;
  logic rx_bit_value;
  logic rx_frame_done;
  logic inv = 1'b0;
  int error_cnt = 0;
  int compares = 0;

  brg_top brg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_frame_end(tx_frame_end), .tx_serial_clk(tx_serial_clk), .tx_buffer_data(tx_buffer_data),
    .tx_buffer_load(tx_buffer_load), .serial_receive_pin(serial_receive_pin), .rx_serial_clk(rx_serial_clk),
    .rx_bit_strobe(rx_bit_strobe), .rx_bit_value(rx_bit_value), .rx_frame_done(rx_frame_done));
  brg_remote_uart brg_remote_uart_inst (.pclk(pclk), .inv(inv), .line(serial_receive_pin));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task tally_and_finish();
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // One APB transfer; an idle cycle follows so psel never changes twice at one edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; a hang is left to the watchdog
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] xq, input logic xe, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, xq, q);
    chk(nm, {31'h0, xe}, {31'h0, e});
  endtask

  // Edges from one change of the transmit clock to the next
  task half(output int c);
    logic s;
    s = tx_serial_clk;
    c = 0;
    while (tx_serial_clk === s && c < 99)
    begin
      @(posedge pclk);
      c++;
    end
    s = tx_serial_clk;
    c = 0;
    while (tx_serial_clk === s && c < 99)
    begin
      @(posedge pclk);
      c++;
    end
  endtask

  // Collect latched bits until the frame completes
  task grab(output logic [9:0] v, output int c, output int d);
    int n;
    v = 10'h000;
    c = 0;
    d = 0;
    n = 0;
    while (d == 0 && n < 800)
    begin
      @(posedge pclk);
      n++;
      if (rx_bit_strobe === 1'b1)
      begin
        v = {rx_bit_value, v[9:1]};
        c++;
      end
      if (rx_frame_done === 1'b1)
        d++;
    end
  endtask

  task pulse_end();
    tx_frame_end <= 1'b1;
    @(posedge pclk);
    tx_frame_end <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic e;
    logic [7:0] b;
    logic [9:0] v;
    int c;
    int d;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0, 1'b0, "ctrl_reset");
    rd(8'h04, 32'hFF, 1'b0, "div_reset");
    rd(8'h10, 32'h0, 1'b1, "unmapped");
    wr(8'h04, 32'h1);
    rd(8'h04, 32'hFF, 1'b0, "div_below_min");
    wr(8'h04, 32'h4);
    rd(8'h04, 32'h4, 1'b0, "div_set");
    // Transmit with doubled base clock: half period is k pclk cycles
    wr(8'h00, 32'hC8);
    wr(8'h08, 32'hA5);
    chk("txb_data", 32'hA5, {24'h0, tx_buffer_data});
    half(c);
    chk("tx_half", 32'd4, c);
    wr(8'h08, 32'h3C);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("tx_pending", 32'h3, {30'h0, q[18:17]});
    pulse_end();
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("tx_busy", 32'h1, {30'h0, q[18:17]});
    pulse_end();
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("tx_idle", 32'h0, {30'h0, q[18:17]});
    half(c);
    chk("tx_keeps", 32'd4, c);
    wr(8'h00, 32'h88);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("tx_count_off", 32'h0, {24'h0, q[7:0]});
    chk("tx_clk_off", 32'h0, {31'h0, tx_serial_clk});
    // Receive over both polarities and both base clocks, transmitter also on
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'h0);
      inv <= i[0];
      repeat (8) @(posedge pclk);
      wr(8'h00, 32'hE0 | {27'h0, i[0], i[1], 3'h0});
      b = 8'h5A + i[7:0];
      fork
        brg_remote_uart_inst.send(b, i[1] ? 8 : 16);
        grab(v, c, d);
      join
      chk("rx_bits", {22'h0, 1'b1, ^b, b}, {22'h0, v});
      chk("rx_strobes", 32'd10, c);
      chk("rx_done", 32'd1, d);
      apb(1'b0, 8'h0C, 32'h0, q, e);
      chk("rx_stopped", 32'h0, {23'h0, q[16:8]});
    end
    // Start-level pulse shorter than k ticks: the resample finds idle and drops back
    brg_remote_uart_inst.pulse(3);
    repeat (12) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("rx_glitch", 32'h0, {23'h0, q[16:8]});
    wr(8'h00, 32'h0);
    rd(8'h0C, 32'h0, 1'b0, "status_off");
    tally_and_finish();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
